// ===== iscr_pkg.sv
package iscr_pkg;

   // ==========================================
   // register offsets (7-bit word address)
   localparam logic [6:0] ADDR_FLT_EN   = 7'h01;
   localparam logic [6:0] ADDR_FLT_DIS  = 7'h02;
   localparam logic [6:0] ADDR_FLT_KEY  = 7'h03;
   localparam logic [6:0] ADDR_CHIP1    = 7'h1A;
   localparam logic [6:0] ADDR_CHIP2    = 7'h1B;
   localparam logic [6:0] ADDR_CHIP3    = 7'h1C;
   localparam logic [6:0] ADDR_DRDY_CFG = 7'h35;
   localparam logic [6:0] ADDR_RATE     = 7'h36;
   localparam logic [6:0] ADDR_RANGE    = 7'h38;
   localparam logic [6:0] ADDR_FILTER   = 7'h39;
   localparam logic [6:0] ADDR_STATUS   = 7'h3C;
   localparam logic [6:0] ADDR_ORIENT   = 7'h74;
   localparam logic [6:0] ADDR_SAVE     = 7'h76;
   localparam logic [6:0] ADDR_VERSION  = 7'h7E;

   // ==========================================
   // field values and reset values
   localparam logic [7:0] SAVE_ALL      = 8'h00;
   localparam logic [7:0] SAVE_FAULT    = 8'h01;
   localparam logic [7:0] FLT_ACC_BIT   = 8'h08;
   localparam logic [7:0] FLT_GYR_BIT   = 8'h10;
   localparam logic [7:0] FLT_EN_RST    = 8'h18;
   localparam logic [7:0] KEY_FIRST     = 8'h96;
   localparam logic [7:0] KEY_SECOND    = 8'h78;
   localparam int         STAT_UNLK_POS = 1;
   localparam logic [5:0] AXIS_RST      = 6'h3F;
   localparam int         AXIS_BITS     = 6;
   localparam int         CHIPS         = 3;
   localparam int         WORD_BITS     = 16;

   // ==========================================
   // timing
   localparam int CLK_HZ         = 25_000_000;
   localparam int READY_MS       = 300;
   localparam int READY_CYCLES   = CLK_HZ / 1000 * READY_MS;

   // ==========================================
   // types
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } iscr_word_t;

   typedef struct packed {
      logic fault;
      logic filter;
      logic rate;
      logic drdy_cfg;
      logic range;
      logic orient;
   } iscr_save_t;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b10
   } iscr_key_t;

endpackage

// ===== iscr_regs.sv
`timescale 1ns/1ps
`default_nettype none

module iscr_regs #(
   parameter int         READY_CYC = iscr_pkg::READY_CYCLES,
   // arbitrary neutral version values
   parameter logic [7:0] HW_VER    = 8'h01,
   parameter logic [7:0] SW_VER    = 8'h01
) (
   // core clock and reset
   input  wire logic                           clock_i,
   input  wire logic                           rst_n_i,
   // spi link
   input  wire logic                           sclk_i,
   input  wire logic                           cs_n_i,
   input  wire logic                           mosi_i,
   output logic                                miso_o,
   output logic                                miso_oe_o,
   // sensor health and axis selection
   input  wire logic [iscr_pkg::CHIPS*6-1:0]   axis_healthy_i,
   output logic      [iscr_pkg::CHIPS*6-1:0]   axis_include_o,
   output logic      [iscr_pkg::CHIPS*6-1:0]   axis_output_o,
   // fault checks and nonvolatile save
   output logic      [7:0]                     fault_enable_o,
   output iscr_pkg::iscr_save_t                save_req_o,
   output logic                                unlocked_o,
   output logic                                ready_o
);

   // ==========================================
   // link domain: receive
   logic [3:0]  rx_cnt;
   logic [14:0] rx_sh;
   logic [15:0] rx_word;
   logic        rx_tog;

   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rx_cnt <= 4'h0;
         rx_sh  <= 15'h0000;
      end else begin
         rx_cnt <= rx_cnt + 4'h1;
         rx_sh  <= {rx_sh[13:0], mosi_i};
      end
   end

   always_ff @(posedge sclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_word <= 16'h0000;
         rx_tog  <= 1'b0;
      end else if (!cs_n_i && rx_cnt == 4'hF) begin
         rx_word <= {rx_sh, mosi_i};
         rx_tog  <= ~rx_tog;
      end
   end

   // ==========================================
   // link domain: transmit
   logic [3:0]  tx_cnt;
   logic [14:0] tx_sh;
   logic [15:0] reply;

   // reply only changes just after a word ends, well inside the gap
   always_ff @(negedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         tx_cnt <= 4'h0;
         tx_sh  <= 15'h0000;
         miso_o <= 1'b0;
      end else begin
         tx_cnt <= tx_cnt + 4'h1;
         if (tx_cnt == 4'h0) begin
            miso_o <= reply[15];
            tx_sh  <= reply[14:0];
         end else begin
            miso_o <= tx_sh[14];
            tx_sh  <= {tx_sh[13:0], 1'b0};
         end
      end
   end

   // ==========================================
   // crossings into the core domain
   logic [2:0] tog_sy;
   logic [2:0] cs_sy;
   logic       tog_seen;
   logic       cs_q;
   logic       word_ev;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tog_sy <= 3'b000;
         cs_sy  <= 3'b111;
      end else begin
         tog_sy <= {tog_sy[1:0], rx_tog};
         cs_sy  <= {cs_sy[1:0], cs_n_i};
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tog_seen <= 1'b0;
         cs_q     <= 1'b1;
      end else begin
         if (tog_sy[1] == tog_sy[2]) begin
            tog_seen <= tog_sy[2];
         end
         if (cs_sy[1] == cs_sy[2]) begin
            cs_q <= cs_sy[2];
         end
      end
   end

   assign word_ev = (tog_sy[1] == tog_sy[2]) && (tog_sy[2] != tog_seen);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         miso_oe_o <= 1'b0;
      end else begin
         miso_oe_o <= ~cs_q;
      end
   end

   // ==========================================
   // startup delay
   logic [$clog2(READY_CYC+1)-1:0] rdy_cnt;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdy_cnt <= '0;
         ready_o <= 1'b0;
      end else if (!ready_o) begin
         if (rdy_cnt == $bits(rdy_cnt)'(READY_CYC - 1)) begin
            ready_o <= 1'b1;
         end
         rdy_cnt <= rdy_cnt + 1'b1;
      end
   end

   // ==========================================
   // decoded word
   iscr_pkg::iscr_word_t w;
   logic                 wr_ev;
   logic                 rd_ev;

   assign w     = iscr_pkg::iscr_word_t'(rx_word);
   assign wr_ev = word_ev && ready_o && w.wr;
   assign rd_ev = word_ev && ready_o && !w.wr;

   function automatic logic hit(input logic [6:0] a,
                                input logic [6:0] b);
      hit = (a == b);
   endfunction

   // ==========================================
   // unlock sequence
   iscr_pkg::iscr_key_t key_st;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         key_st <= iscr_pkg::KEY_IDLE;
      end else if (wr_ev && hit(w.addr, iscr_pkg::ADDR_FLT_KEY)) begin
         unique case (key_st)
            iscr_pkg::KEY_IDLE: begin
               if (w.data == iscr_pkg::KEY_FIRST) begin
                  key_st <= iscr_pkg::KEY_HALF;
               end
            end
            iscr_pkg::KEY_HALF: begin
               if (w.data == iscr_pkg::KEY_SECOND) begin
                  key_st <= iscr_pkg::KEY_OPEN;
               end else if (w.data != iscr_pkg::KEY_FIRST) begin
                  key_st <= iscr_pkg::KEY_IDLE;
               end
            end
            iscr_pkg::KEY_OPEN: begin
               key_st <= iscr_pkg::KEY_OPEN;
            end
            default: begin
               key_st <= iscr_pkg::KEY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         unlocked_o <= 1'b0;
      end else begin
         unlocked_o <= (key_st == iscr_pkg::KEY_OPEN);
      end
   end

   // ==========================================
   // fault check enables
   localparam logic [7:0] FLT_MASK =
      iscr_pkg::FLT_ACC_BIT | iscr_pkg::FLT_GYR_BIT;
   logic unlocked_now;

   assign unlocked_now = (key_st == iscr_pkg::KEY_OPEN);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         fault_enable_o <= iscr_pkg::FLT_EN_RST;
      end else if (wr_ev && unlocked_now) begin
         if (hit(w.addr, iscr_pkg::ADDR_FLT_EN)) begin
            fault_enable_o <= fault_enable_o
                              | (w.data & FLT_MASK);
         end else if (hit(w.addr, iscr_pkg::ADDR_FLT_DIS)) begin
            fault_enable_o <= fault_enable_o
                              & ~(w.data & FLT_MASK);
         end
      end
   end

   // ==========================================
   // axis inclusion registers
   logic [iscr_pkg::CHIPS*6-1:0] incl;
   logic [6:0]                   chip_addr [iscr_pkg::CHIPS];

   assign chip_addr[0] = iscr_pkg::ADDR_CHIP1;
   assign chip_addr[1] = iscr_pkg::ADDR_CHIP2;
   assign chip_addr[2] = iscr_pkg::ADDR_CHIP3;

   genvar c;
   generate
      for (c = 0; c < iscr_pkg::CHIPS; c++) begin : g_chip
         always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
               incl[c*6 +: 6] <= iscr_pkg::AXIS_RST;
            end else if (wr_ev && hit(w.addr, chip_addr[c])) begin
               incl[c*6 +: 6] <= w.data[5:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         axis_include_o <= {(iscr_pkg::CHIPS*6){1'b1}};
         axis_output_o  <= '0;
      end else begin
         axis_include_o <= incl;
         axis_output_o  <= incl & axis_healthy_i;
      end
   end

   // ==========================================
   // nonvolatile save requests
   iscr_pkg::iscr_save_t next_save;

   always_comb begin
      next_save = '0;
      if (wr_ev && hit(w.addr, iscr_pkg::ADDR_SAVE)) begin
         if (w.data == iscr_pkg::SAVE_ALL) begin
            next_save.orient   = 1'b1;
            next_save.range    = 1'b1;
            next_save.drdy_cfg = 1'b1;
            next_save.rate     = 1'b1;
            next_save.filter   = 1'b1;
         end
         if (w.data == iscr_pkg::SAVE_FAULT) begin
            next_save.fault = 1'b1;
         end
         if (w.data == {1'b0, iscr_pkg::ADDR_ORIENT}) begin
            next_save.orient = 1'b1;
         end
         if (w.data == {1'b0, iscr_pkg::ADDR_RANGE}) begin
            next_save.range = 1'b1;
         end
         if (w.data == {1'b0, iscr_pkg::ADDR_DRDY_CFG}) begin
            next_save.drdy_cfg = 1'b1;
         end
         if (w.data == {1'b0, iscr_pkg::ADDR_RATE}) begin
            next_save.rate = 1'b1;
         end
         if (w.data == {1'b0, iscr_pkg::ADDR_FILTER}) begin
            next_save.filter = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         save_req_o <= '0;
      end else begin
         save_req_o <= next_save;
      end
   end

   // ==========================================
   // read answer, returned in the next word
   logic [15:0] next_reply;

   always_comb begin
      next_reply = 16'h0000;
      unique case (w.addr)
         iscr_pkg::ADDR_FLT_EN:
            next_reply = {8'h00, fault_enable_o};
         iscr_pkg::ADDR_CHIP1:
            next_reply = {10'h000, incl[5:0]};
         iscr_pkg::ADDR_CHIP2:
            next_reply = {10'h000, incl[11:6]};
         iscr_pkg::ADDR_CHIP3:
            next_reply = {10'h000, incl[17:12]};
         iscr_pkg::ADDR_STATUS: begin
            next_reply[iscr_pkg::STAT_UNLK_POS] = unlocked_now;
         end
         iscr_pkg::ADDR_VERSION:
            next_reply = {HW_VER, SW_VER};
         default:
            next_reply = 16'h0000;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         reply <= 16'h0000;
      end else if (rd_ev) begin
         reply <= next_reply;
      end else if (wr_ev) begin
         reply <= 16'h0000;
      end
   end

endmodule

`default_nettype wire

// ===== iscr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the config register bank
module iscr_monitor #(
   parameter int READY_CYC = 20
) (
   // core
   input wire logic                 clock_i,
   input wire logic                 rst_n_i,
   // link
   input wire logic                 sclk_i,
   input wire logic                 cs_n_i,
   input wire logic                 mosi_i,
   input wire logic                 miso_o,
   input wire logic                 miso_oe_o,
   // user side
   input wire logic [17:0]          axis_healthy_i,
   input wire logic [17:0]          axis_include_o,
   input wire logic [17:0]          axis_output_o,
   input wire logic [7:0]           fault_enable_o,
   input wire iscr_pkg::iscr_save_t save_req_o,
   input wire logic                 unlocked_o,
   input wire logic                 ready_o
);
   logic [31:0] cnt;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   // cycles since reset release, saturating
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) cnt <= '0;
      else if (cnt < READY_CYC + 2) cnt <= cnt + 1;
   end

   rst_vals_a: assert property (disable iff (1'b0) !rst_n_i |=>
      fault_enable_o == 8'h18 && (&axis_include_o) && !unlocked_o && !ready_o)
      else $error("reset values wrong");
   ready_late_a: assert property (ready_o |-> cnt >= READY_CYC - 1)
      else $error("ready too early");
   ready_soon_a: assert property (!ready_o |-> cnt <= READY_CYC + 1)
      else $error("ready too late");
   flt_bits_a: assert property ((fault_enable_o & 8'hE7) == 8'h00)
      else $error("fault enable bit outside checks");
   flt_lock_a: assert property ($changed(fault_enable_o) |-> unlocked_o)
      else $error("fault enable changed while locked");
   unlock_hold_a: assert property (unlocked_o |=> unlocked_o)
      else $error("unlock lost without reset");
   out_and_a: assert property ($past(rst_n_i) |->
      axis_output_o == (axis_include_o & $past(axis_healthy_i)))
      else $error("axis output not include and healthy");
   save_pulse_a: assert property (save_req_o != '0 |=> save_req_o == '0)
      else $error("save request longer than a cycle");
   save_kind_a: assert property (save_req_o != '0 |->
      $onehot(save_req_o) || save_req_o == 6'h1F)
      else $error("save request mix illegal");
   oe_idle_a: assert property (cs_n_i [*6] |-> !miso_oe_o)
      else $error("miso driven while deselected");
   oe_frame_a: assert property (!cs_n_i [*6] |-> miso_oe_o)
      else $error("miso not driven while selected");

   cover property (save_req_o == 6'h1F);
   cover property ($rose(unlocked_o));
   cover property ($changed(fault_enable_o));
endmodule

bind iscr_regs iscr_monitor #(.READY_CYC(READY_CYC)) u_mon (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
   .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
   .miso_oe_o(miso_oe_o), .axis_healthy_i(axis_healthy_i),
   .axis_include_o(axis_include_o), .axis_output_o(axis_output_o),
   .fault_enable_o(fault_enable_o), .save_req_o(save_req_o),
   .unlocked_o(unlocked_o), .ready_o(ready_o));
`default_nettype wire

// ===== iscr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// spi master partner, one 16-bit word per call
module iscr_spi_host (
   // link
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      // start off the core clock's edges
      #7.3;
      cs_n_o = 1'b0;
      #200;
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         mosi_o = tx[i];
         #16;
         sclk_o = 1'b1;
         rx[i] = miso_i;
         #16;
      end
      #200;
      cs_n_o = 1'b1;
      // released line no longer shows the last bit
      mosi_o = ~mosi_o;
      #15000;
   endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// testbench
module tb_top;
   localparam logic [7:0] SD [8] = '{8'h00, 8'h01, 8'h74, 8'h38,
                                     8'h35, 8'h36, 8'h39, 8'h22};
   localparam logic [5:0] SE [8] = '{6'h1F, 6'h20, 6'h01, 6'h02,
                                     6'h04, 6'h08, 6'h10, 6'h00};
   logic                 clock_i = 1'b0;
   logic                 rst_n_i = 1'b0;
   logic [17:0]          healthy = '1;
   wire logic            sclk, cs_n, mosi, miso, miso_oe;
   logic [17:0]          incl, aout;
   logic [7:0]           fen;
   iscr_pkg::iscr_save_t save, seen_save;
   logic                 unl, rdy;
   int                   fails = 0;
   int                   num_checks = 0;

   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) if (save != '0) seen_save <= save;

   iscr_regs #(.READY_CYC(60), .HW_VER(8'hA5), .SW_VER(8'h5B)) u_dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
      .axis_healthy_i(healthy), .axis_include_o(incl), .axis_output_o(aout),
      .fault_enable_o(fen), .save_req_o(save), .unlocked_o(unl),
      .ready_o(rdy));
   iscr_spi_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
      .miso_i(miso));

   task automatic chk(string n, logic [17:0] s, logic [17:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(logic [6:0] a, logic [7:0] d);
      logic [15:0] r;
      u_host.xfer({1'b1, a, d}, r);
   endtask

   task automatic rd(logic [6:0] a, output logic [15:0] v);
      logic [15:0] r;
      u_host.xfer({1'b0, a, 8'h00}, r);
      u_host.xfer(16'h0000, v);
   endtask

   task automatic do_reset(input bit early);
      logic [15:0] r;
      @(posedge clock_i) rst_n_i <= 1'b0;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      // a write that ends before ready must be dropped
      if (early) u_host.xfer({1'b1, 7'h1A, 8'h00}, r);
      for (int i = 0; i < 100 && rdy !== 1'b1; i++) begin
         @(posedge clock_i);
      end
      chk("ready", 18'(rdy), 18'h1);
      if (early) chk("early", incl, 18'h3FFFF);
   endtask

   task automatic t_defaults();
      logic [15:0] v;
      chk("fen", 18'(fen), 18'h18);
      chk("incl", incl, 18'h3FFFF);
      rd(7'h01, v); chk("rd01", 18'(v), 18'h18);
      rd(7'h02, v); chk("rd02", 18'(v), 18'h0);
      rd(7'h7E, v); chk("ver", 18'(v), 18'hA55B);
      rd(7'h1A, v); chk("rd1a", 18'(v), 18'h3F);
      $display("defaults done");
   endtask

   task automatic t_unlock();
      logic [15:0] v;
      wr(7'h02, 8'h08); chk("locked", 18'(fen), 18'h18);
      wr(7'h03, 8'h96); wr(7'h03, 8'h55); wr(7'h03, 8'h78);
      chk("badkey", 18'(unl), 18'h0);
      wr(7'h03, 8'h96); wr(7'h03, 8'h96); wr(7'h03, 8'h78);
      chk("unl", 18'(unl), 18'h1);
      rd(7'h3C, v); chk("stat", 18'(v[1]), 18'h1);
      wr(7'h02, 8'h08); chk("dis", 18'(fen), 18'h10);
      wr(7'h02, 8'h00); chk("zero", 18'(fen), 18'h10);
      wr(7'h01, 8'h08); chk("en", 18'(fen), 18'h18);
      wr(7'h02, 8'h10); rd(7'h01, v); chk("rd01", 18'(v), 18'h08);
      $display("unlock done");
   endtask

   task automatic t_save();
      for (int i = 0; i < 8; i++) begin
         seen_save = '0;
         wr(7'h76, SD[i]);
         chk("save", 18'(seen_save), 18'(SE[i]));
      end
      $display("save done");
   endtask

   task automatic t_axis();
      logic [15:0] v;
      @(posedge clock_i) healthy <= 18'h2FFF7;
      wr(7'h1B, 8'h2A);
      chk("incl", incl, {6'h3F, 6'h2A, 6'h3F});
      chk("out", aout, {6'h3F, 6'h2A, 6'h3F} & 18'h2FFF7);
      rd(7'h1B, v); chk("rd1b", 18'(v), 18'h2A);
      do_reset(1'b1);
      chk("relock", 18'(unl), 18'h0);
      chk("fen", 18'(fen), 18'h18);
      chk("incl", incl, 18'h3FFFF);
      $display("axis and reset done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #1500000;
      fails++;
      report_and_stop();
   end

   initial begin
      // host stays idle until reset is released
      do_reset(1'b0);
      t_defaults();
      t_unlock();
      t_save();
      t_axis();
      report_and_stop();
   end
endmodule
`default_nettype wire
